// *** bench/host_link.sv ***
// host controller model: sends command frames onto the device line and collects reply frames
`timescale 1ns/1ps
`default_nettype none
module host_link #(
	parameter int BIT_CYC = 100
) (
	// clock
	input  wire logic clk_i,
	// lines: command out, reply in, relayed copy in
	output logic      tx_o,
	input  wire logic rx_i,
	input  wire logic fwd_i
);
	int relay_err;

	// line idles high between frames
	initial begin
		tx_o = 1'b1;
		relay_err = 0;
	end

	// one frame, msb first, relayed copy checked at mid bit
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b0, b, 1'b1};
		for (int i = 9; i >= 0; i--) begin
			@(posedge clk_i);
			tx_o <= f[i];
			repeat (BIT_CYC / 2) @(posedge clk_i);
			#1 if (fwd_i !== f[i]) relay_err++;
			repeat (BIT_CYC / 2 - 1) @(posedge clk_i);
		end
	endtask : send_byte

	// wait up to lim cycles for a start bit, then sample eight bits at mid bit
	task automatic get_byte(input int lim, output logic [7:0] b, output int wt);
		wt = 0;
		b = 8'h00;
		while (rx_i !== 1'b0 && wt < lim) begin
			@(posedge clk_i);
			#1 wt++;
		end
		if (wt < lim) begin
			repeat (BIT_CYC + BIT_CYC / 2) @(posedge clk_i);
			for (int i = 7; i >= 0; i--) begin
				#1 b[i] = rx_i;
				repeat (BIT_CYC) @(posedge clk_i);
			end
		end
	endtask : get_byte
endmodule : host_link
`default_nettype wire

// *** bench/tb_daisy_chain_register_link.sv ***
// self-checking bench of the chain link block
`timescale 1ns/1ps
`default_nettype none
module tb_daisy_chain_register_link;
	import link_pkg::*;
	localparam int         BIT  = 100;
	localparam int         RMAX = 600; // 3 us reply bound
	localparam logic [7:0] SYNC = 8'hA5;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, last;
	logic        iso_rx, uart_rx, uart_tx, iso_tx, wr, awake, on_iso;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	reg_req_t    req;
	reg_rsp_t    rsp;
	meas_set_t   meas;
	int          fails, compares, wr_n;
	logic [7:0]  wr_a;
	logic [15:0] wr_d;

	daisy_chain_register_link u_daisy_chain_register_link (.clk_i(clk), .rstn_i(rstn),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .uart_rx_i(uart_rx),
		.uart_tx_o(uart_tx), .iso_rx_i(iso_rx), .iso_tx_o(iso_tx), .last_node_i(last),
		.reg_req_o(req), .reg_wr_o(wr), .reg_rsp_i(rsp), .meas_i(meas), .awake_o(awake),
		.rx_on_iso_o(on_iso));
	host_link u_host_link (.clk_i(clk), .tx_o(uart_rx), .rx_i(uart_tx), .fwd_i(iso_tx));

	// clock and register-file write capture
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (wr === 1'b1) begin
			wr_n++;
			wr_a = req.addr;
			wr_d = req.wdata;
		end
	end

	task automatic conclude;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	function automatic logic [7:0] crc8(input logic [7:0] q[$]);
		logic [7:0] c;
		c = 8'hFF;
		foreach (q[j])
			for (int i = 7; i >= 0; i--)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ q[j][i]) ? 8'h1D : 8'h00);
		return c ^ 8'hFF;
	endfunction : crc8

	function automatic logic [7:0] wreply(input logic [2:0] st);
		logic [2:0] c;
		logic [7:0] b;
		c = 3'h0;
		b = {2'b00, st, 3'b000};
		for (int i = 7; i >= 3; i--)
			c = {c[1:0], 1'b0} ^ ((c[2] ^ b[i]) ? 3'h3 : 3'h0);
		return {b[7:3], c};
	endfunction : wreply

	// apb transfer: setup, access until pready, then release
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(n < 50, "apb hang");
		if (n >= 50) conclude();
	endtask : apb

	// command: sync, id, address, data for writes, crc (optionally corrupted)
	task automatic cmd(input logic [7:0] id, input logic [7:0] a, input logic [15:0] d, input logic bad);
		logic [7:0] q[$];
		q = {SYNC, id, a};
		if (id[7]) q = {q, d[15:8], d[7:0]};
		q.push_back(crc8(q) ^ {7'h00, bad});
		foreach (q[i]) u_host_link.send_byte(q[i]);
	endtask : cmd

	// collect reply bytes, the first within the reply bound
	task automatic reply(input logic [7:0] e[$]);
		logic [7:0] b;
		int         wt;
		foreach (e[i]) begin
			u_host_link.get_byte(i ? 4 * BIT : RMAX, b, wt);
			chk(wt < (i ? 4 * BIT : RMAX), "reply late or missing");
			chk(b === e[i], "reply byte");
			if (wt >= (i ? 4 * BIT : RMAX)) conclude();
		end
	endtask : reply

	task automatic t_regs;
		logic [31:0] rd;
		logic        err;
		apb(1'b0, 12'h004, 32'h0000_0000, rd, err);
		chk(rd[5:0] === 6'h01 && err === 1'b0, "mrcfg reset");
		apb(1'b0, 12'h0F0, 32'h0000_0000, rd, err);
		chk(err === 1'b1, "unmapped not refused");
		apb(1'b1, 12'h004, 32'h0000_0005, rd, err);
		apb(1'b0, 12'h004, 32'h0000_0000, rd, err);
		chk(rd[5:0] === 6'h05, "mrcfg write");
	endtask : t_regs

	task automatic t_wake;
		u_host_link.send_byte(8'hFF);
		repeat (3 * BIT) @(posedge clk);
		chk(awake === 1'b1 && on_iso === 1'b0, "wake direction");
		u_host_link.relay_err = 0;
	endtask : t_wake

	task automatic t_write;
		int n0;
		n0 = wr_n;
		cmd(8'h80, 8'h12, 16'hBEEF, 1'b0);
		reply('{wreply(3'b000)});
		chk(wr_n == n0 + 1 && wr_a === 8'h12 && wr_d === 16'hBEEF, "directed write");
		chk(u_host_link.relay_err == 0, "relay copy");
	endtask : t_write

	task automatic t_refuse;
		logic [7:0] b;
		int         wt, n0;
		for (int k = 0; k < 2; k++) begin
			n0 = wr_n;
			cmd(k ? 8'h85 : 8'h80, 8'h12, 16'h5555, k == 0);
			u_host_link.get_byte(1000, b, wt);
			chk(wt >= 1000 && wr_n == n0, "command not discarded");
		end
	endtask : t_refuse

	task automatic t_read;
		logic [7:0] e[$];
		e = {8'h12, 8'h34};
		cmd(8'h00, 8'h12, 16'h0000, 1'b0);
		reply({e, crc8(e)});
		e = {meas[0][15:8], meas[0][7:0], meas[2][15:8], meas[2][7:0]};
		cmd(8'h00, 8'h30, 16'h0000, 1'b0);
		reply({e, crc8(e)});
	endtask : t_read

	task automatic t_bcast;
		int n0;
		n0 = wr_n;
		last <= 1'b1;
		rsp.crc_bad <= 1'b1;
		rsp.addr_bad <= 1'b1;
		rsp.diag_fault <= 1'b1;
		cmd(8'hBF, 8'h22, 16'h0F0F, 1'b0);
		reply('{wreply(3'b111)});
		chk(wr_n == n0 + 1 && wr_d === 16'h0F0F, "broadcast write");
		last <= 1'b0;
	endtask : t_bcast

	// counters, then sleep and a new wake from the iso side
	task automatic t_sleep;
		logic [31:0] rd;
		logic        err;
		apb(1'b0, 12'h00C, 32'h0000_0000, rd, err);
		chk(rd === 32'h0000_0401, "error and command counters");
		apb(1'b1, 12'h000, 32'h0000_0100, rd, err);
		@(posedge clk);
		chk(awake === 1'b0, "sleep request");
		iso_rx <= 1'b0;
		repeat (BIT) @(posedge clk);
		iso_rx <= 1'b1;
		repeat (BIT) @(posedge clk);
		chk(awake === 1'b1 && on_iso === 1'b1, "wake on iso side");
	endtask : t_sleep

	// main sequence
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		{psel, penable, pwrite, last} = 4'h0;
		iso_rx = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rsp = '{16'h1234, 1'b0, 1'b0, 1'b0};
		for (int i = 0; i < 6; i++) meas[i] = 16'hA000 + 16'(i * 16'h0111);
		{fails, compares, wr_n} = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_wake();
		t_write();
		t_refuse();
		t_read();
		t_bcast();
		t_sleep();
		conclude();
	end

	// hang limit
	initial begin
		#400000;
		fails++;
		conclude();
	end
endmodule : tb_daisy_chain_register_link
`default_nettype wire

// *** verilog/daisy_chain_register_link.sv ***
// chain link command engine: relay, decode, crc check, register access and reply
//
// Overview of operation
// - wake on whichever interface sees activity; it becomes receive, the other transmit
// - direction stays fixed while awake; only sleep and a new wake change it
// - reply starts 1.7 us after the command ends, never later than 3 us
// - every bit arriving on the receive interface is relayed onto the transmit interface
// - a directed write updates one register, only in the addressed device
// - broadcast write: store, swap relay direction for the reply, last node answers
// - frames are start bit, eight data bits msb first, stop bit
// - identifier frame: bit 7 write, bits 5:0 target device
// - all-ones identifier is broadcast and cannot be assigned to a device
// - all-zeros identifier addresses the device only before enumeration
// - address frame selects the register read or written
// - 8-bit crc, poly 0x1d, init and final xor all ones, covers sync onward
// - a crc mismatch discards the command with no reply
// - accepted writes get a reply frame; broadcast writes only from the last node
// - reply frame carries a 3-bit crc, poly x^3+x+1, in bits 2:0
// - reply bits 7:6 zero, 5 register crc error, 4 bad address, 3 diagnostics fault
// - directed and broadcast reads return one register
// - multi-read address returns the results selected in the multi-read config
`timescale 1ns/1ps
`default_nettype none
`include "link_regs.svh"
module daisy_chain_register_link #(
	parameter logic [7:0] SYNC_PAT   = 8'hA5,
	parameter logic [7:0] MREAD_ADDR = 8'h30
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rstn_i,
	// apb slave
	input  wire logic        [11:0] paddr_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic        [31:0] pwdata_i,
	output logic             [31:0] prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	// serial interfaces
	input  wire logic               uart_rx_i,
	output logic                    uart_tx_o,
	input  wire logic               iso_rx_i,
	output logic                    iso_tx_o,
	// chain position, high on the final node
	input  wire logic               last_node_i,
	// device register file
	output link_pkg::reg_req_t      reg_req_o,
	output logic                    reg_wr_o,
	input  wire link_pkg::reg_rsp_t reg_rsp_i,
	// measurement results
	input  wire link_pkg::meas_set_t meas_i,
	// status
	output logic                    awake_o,
	output logic                    rx_on_iso_o
);
	import link_pkg::*;

	localparam int         RDLY_MAX  = `REPLY_MAX_CYC;
	localparam logic [6:0] BIT_LAST  = 7'(`BIT_CYC - 1);
	localparam logic [9:0] RDLY_LAST = 10'(`REPLY_CYC - 1);

	////////////////////////////////////////////////////////////////////////////////
	// crc helpers

	// 8-bit crc, one byte msb first
	function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? `CRC8_POLY : 8'h00);
		end
		return r;
	endfunction : crc8_byte

	// 3-bit crc over the five upper reply bits
	function automatic logic [2:0] crc3_bits(input logic [4:0] d);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			r = {r[1:0], 1'b0} ^ ((r[2] ^ d[i]) ? `CRC3_POLY : 3'h0);
		end
		return r;
	endfunction : crc3_bits

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic             awake_q;
	logic             dir_q;        // 1: receive on iso, transmit on uart
	logic             swap_q;
	logic       [5:0] dev_id_q;
	logic             enum_q;
	logic       [5:0] mrcfg_q;
	logic       [7:0] crc_err_q;
	logic       [7:0] cmd_cnt_q;
	logic      [31:0] prdata_q;
	cmd_state_t       st_q;
	logic       [2:0] fcnt_q;
	logic       [7:0] crc_q;
	logic       [7:0] id_q;
	logic       [7:0] addr_q;
	logic      [15:0] data_q;
	logic             reg_wr_q;
	logic       [9:0] dly_q;
	logic [11:0][7:0] tx_mem_q;
	logic       [3:0] tx_len_q;
	logic             tx_crc_q;
	logic       [3:0] tx_idx_q;
	logic       [3:0] tx_bit_q;
	logic       [6:0] tx_tick_q;
	logic       [7:0] tcrc_q;
	logic             uart_tx_q;
	logic             iso_tx_q;

	////////////////////////////////////////////////////////////////////////////////
	// apb decode

	wire        apb_acc  = psel_i & penable_i;
	wire        apb_wr   = apb_acc & pwrite_i;
	wire        hit_ctrl = paddr_i == `CTRL_OFS;
	wire        hit_mcfg = paddr_i == `MRCFG_OFS;
	wire        hit_stat = paddr_i == `STAT_OFS;
	wire        hit_errs = paddr_i == `ERRS_OFS;
	wire        mapped   = hit_ctrl | hit_mcfg | hit_stat | hit_errs;
	wire        sleep_rq = apb_wr & hit_ctrl & pwdata_i[`CTRL_SLEEP_BIT];
	wire  [5:0] new_id   = pwdata_i[`CTRL_ID_MSB:0];
	wire [31:0] rd_mux   = hit_ctrl ? {25'h0, enum_q, dev_id_q} :
	                       hit_mcfg ? {26'h0, mrcfg_q} :
	                       hit_stat ? {28'h0, st_q != S_HUNT, swap_q, dir_q, awake_q} :
	                       hit_errs ? {16'h0, cmd_cnt_q, crc_err_q} : 32'h0000_0000;

	assign pready_o  = 1'b1;
	assign pslverr_o = apb_acc & !mapped;
	assign prdata_o  = prdata_q;

	// read data captured in the setup cycle; identifier and multi-read config writes
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_q <= 32'h0000_0000;
			dev_id_q <= `ID_RST;
			enum_q   <= 1'b0;
			mrcfg_q  <= `MRCFG_RST;
		end else begin
			if (psel_i && !penable_i)
				prdata_q <= rd_mux;
			if (apb_wr && hit_ctrl && new_id != `BCAST_ID) begin
				dev_id_q <= new_id;
				enum_q   <= pwdata_i[`CTRL_ENUM_BIT];
			end
			if (apb_wr && hit_mcfg)
				mrcfg_q <= pwdata_i[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// wake, direction and relay paths

	wire rx_line   = dir_q ? iso_rx_i : uart_rx_i;
	wire back_line = dir_q ? uart_rx_i : iso_rx_i;
	wire wake_evt  = !awake_q && (!uart_rx_i || !iso_rx_i);

	// direction latched only at wake-up
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			awake_q <= 1'b0;
			dir_q   <= 1'b0;
		end else if (wake_evt) begin
			awake_q <= 1'b1;
			dir_q   <= !iso_rx_i;
		end else if (sleep_rq) begin
			awake_q <= 1'b0;
		end
	end

	logic rx_valid;
	logic back_valid;
	logic [7:0] rx_byte;

	// command receiver on the receive interface
	frame_rx u_cmd_rx (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.en_i    (awake_q),
		.line_i  (rx_line),
		.byte_o  (rx_byte),
		.valid_o (rx_valid)
	);

	// watches the returning reply while the relay is swapped
	frame_rx u_back_rx (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.en_i    (swap_q),
		.line_i  (back_line),
		.byte_o  (),
		.valid_o (back_valid)
	);

	////////////////////////////////////////////////////////////////////////////////
	// command decode

	wire       is_wr      = id_q[7];
	wire [5:0] tid        = id_q[5:0];
	wire       is_bcast   = tid == `BCAST_ID;
	wire       is_mine    = tid == dev_id_q && !(tid == `DFLT_ID && enum_q) && !is_bcast;
	wire       last_frame = fcnt_q == (is_wr ? 3'd5 : 3'd3);
	wire       take       = st_q == S_RECV && rx_valid && last_frame;
	wire       crc_ok     = (crc_q ^ `CRC8_XOR) == rx_byte;
	wire       crc_bad    = take && !crc_ok;
	wire       exec       = take && crc_ok && (is_mine || is_bcast);
	wire       want_reply = exec && (!is_wr || is_mine || last_node_i);
	wire       set_swap   = exec && is_wr && is_bcast && !last_node_i;

	// write reply byte: status bits over a 3-bit crc
	wire [4:0] wr_status = {2'b00, reg_rsp_i.crc_bad, reg_rsp_i.addr_bad, reg_rsp_i.diag_fault};
	wire [7:0] wr_reply  = {wr_status, crc3_bits(wr_status)};

	// multi-read: selected results packed back to back
	logic [11:0][7:0] pack_d;
	logic       [3:0] pack_n;
	always_comb begin
		pack_d = '0;
		pack_n = 4'h0;
		for (int i = 0; i < 6; i++) begin
			if (mrcfg_q[i]) begin
				pack_d[pack_n]               = meas_i[i][15:8];
				pack_d[4'(pack_n + 4'h1)]    = meas_i[i][7:0];
				pack_n                       = pack_n + 4'h2;
			end
		end
	end

	wire is_mread = addr_q == MREAD_ADDR;

	////////////////////////////////////////////////////////////////////////////////
	// transmit byte and bit selection

	wire [3:0] tx_last  = tx_crc_q ? tx_len_q : 4'(tx_len_q - 4'h1);
	wire [7:0] cur_byte = (tx_idx_q == tx_len_q) ? (tcrc_q ^ `CRC8_XOR) : tx_mem_q[tx_idx_q];
	wire       bit_val  = (tx_bit_q == 4'h0) ? 1'b0 :
	                      (tx_bit_q == 4'h9) ? 1'b1 : cur_byte[3'(4'd8 - tx_bit_q)];
	wire       own_tx   = (st_q == S_SEND) ? bit_val : (swap_q ? back_line : 1'b1);

	////////////////////////////////////////////////////////////////////////////////
	// command engine

	// sync hunt, frame collection and reply sequencing
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q   <= S_HUNT;
			fcnt_q <= 3'h0;
			crc_q  <= `CRC8_INIT;
			dly_q  <= 10'h000;
		end else if (!awake_q) begin
			st_q <= S_HUNT;
		end else begin
			unique case (st_q)
				S_HUNT: if (rx_valid && rx_byte == SYNC_PAT) begin
					crc_q  <= crc8_byte(`CRC8_INIT, rx_byte);
					fcnt_q <= 3'h1;
					st_q   <= S_RECV;
				end
				S_RECV: if (rx_valid) begin
					fcnt_q <= fcnt_q + 3'h1;
					crc_q  <= crc8_byte(crc_q, rx_byte);
					dly_q  <= 10'h000;
					if (last_frame)
						st_q <= want_reply ? S_DELAY : S_HUNT;
				end
				S_DELAY: begin
					dly_q <= dly_q + 10'h001;
					if (dly_q == RDLY_LAST)
						st_q <= S_SEND;
				end
				S_SEND: if (tx_tick_q == 7'h00 && tx_bit_q == 4'h9 && tx_idx_q == tx_last)
					st_q <= S_HUNT;
			endcase
		end
	end

	// command fields by frame position
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			id_q   <= 8'h00;
			addr_q <= 8'h00;
			data_q <= 16'h0000;
		end else if (st_q == S_RECV && rx_valid) begin
			unique case (fcnt_q)
				3'd1:    id_q         <= rx_byte;
				3'd2:    addr_q       <= rx_byte;
				3'd3:    data_q[15:8] <= rx_byte;
				3'd4:    data_q[7:0]  <= rx_byte;
				default: ;
			endcase
		end
	end

	// reply image loaded when the command is executed
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_mem_q <= '0;
			tx_len_q <= 4'h0;
			tx_crc_q <= 1'b0;
		end else if (exec) begin
			tx_crc_q <= !is_wr;
			if (is_wr) begin
				tx_mem_q    <= '0;
				tx_mem_q[0] <= wr_reply;
				tx_len_q    <= 4'h1;
			end else if (is_mread) begin
				tx_mem_q <= pack_d;
				tx_len_q <= pack_n;
			end else begin
				tx_mem_q    <= '0;
				tx_mem_q[0] <= reg_rsp_i.rdata[15:8];
				tx_mem_q[1] <= reg_rsp_i.rdata[7:0];
				tx_len_q    <= 4'h2;
			end
		end
	end

	// bit timer and byte index of the reply
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_idx_q  <= 4'h0;
			tx_bit_q  <= 4'h0;
			tx_tick_q <= 7'h00;
			tcrc_q    <= `CRC8_INIT;
		end else if (st_q != S_SEND) begin
			tx_idx_q  <= 4'h0;
			tx_bit_q  <= 4'h0;
			tx_tick_q <= BIT_LAST;
			tcrc_q    <= `CRC8_INIT;
		end else if (tx_tick_q != 7'h00) begin
			tx_tick_q <= tx_tick_q - 7'h01;
		end else begin
			tx_tick_q <= BIT_LAST;
			if (tx_bit_q != 4'h9) begin
				tx_bit_q <= tx_bit_q + 4'h1;
			end else begin
				tx_bit_q <= 4'h0;
				tx_idx_q <= tx_idx_q + 4'h1;
				tcrc_q   <= crc8_byte(tcrc_q, cur_byte);
			end
		end
	end

	// register write strobe, relay swap and counters
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reg_wr_q  <= 1'b0;
			swap_q    <= 1'b0;
			crc_err_q <= 8'h00;
			cmd_cnt_q <= 8'h00;
		end else begin
			reg_wr_q <= exec && is_wr;
			if (set_swap)
				swap_q <= 1'b1;
			else if (back_valid || !awake_q)
				swap_q <= 1'b0;
			if (crc_bad)
				crc_err_q <= crc_err_q + 8'h01;
			if (exec)
				cmd_cnt_q <= cmd_cnt_q + 8'h01;
		end
	end

	// pin drivers: relay forward, reply or swapped relay backward
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			uart_tx_q <= 1'b1;
			iso_tx_q  <= 1'b1;
		end else begin
			uart_tx_q <= !awake_q || (dir_q ? rx_line : own_tx);
			iso_tx_q  <= !awake_q || (dir_q ? own_tx : rx_line);
		end
	end

	assign uart_tx_o   = uart_tx_q;
	assign iso_tx_o    = iso_tx_q;
	assign reg_req_o   = {is_wr, addr_q, data_q};
	assign reg_wr_o    = reg_wr_q;
	assign awake_o     = awake_q;
	assign rx_on_iso_o = dir_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	dir_fixed_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		awake_q && $past(awake_q) |-> $stable(dir_q))
		else $error("direction changed while awake");

	wake_iso_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		!awake_q && !iso_rx_i |=> awake_q && dir_q)
		else $error("wake on iso did not make iso the receive side");

	reply_delay_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(st_q == S_DELAY) && awake_q |-> (st_q == S_DELAY) [*8] ##[1:RDLY_MAX] st_q == S_SEND)
		else $error("reply start outside delay window");

	relay_fwd_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		awake_q && !dir_q |=> iso_tx_o == $past(uart_rx_i))
		else $error("receive line not relayed forward");

	write_once_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		reg_wr_o |-> is_wr && (is_mine || is_bcast) ##1 !reg_wr_o)
		else $error("register write not single or not addressed");

	swap_cause_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(swap_q) |-> $past(is_bcast && is_wr && !last_node_i))
		else $error("relay swapped without broadcast write");

	start_bit_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		awake_q && st_q == S_SEND && tx_bit_q == 4'h0 |=> !(dir_q ? iso_tx_o : uart_tx_o))
		else $error("reply start bit not low");

	crc_drop_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		crc_bad |=> st_q == S_HUNT && !reg_wr_o)
		else $error("bad crc command not discarded");

	id_enum_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
		reg_wr_o && tid == `DFLT_ID |-> !enum_q || dev_id_q == `DFLT_ID && !enum_q)
		else $error("default identifier accepted after enumeration");

endmodule : daisy_chain_register_link
`default_nettype wire

// *** verilog/daisy_chain_register_link_fix.sv ***
// intentionally empty: no further design content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** verilog/frame_rx.sv ***
// serial byte receiver: start bit, eight data bits msb first, stop bit
`timescale 1ns/1ps
`default_nettype none
`include "link_regs.svh"
module frame_rx (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// line
	input  wire logic       en_i,
	input  wire logic       line_i,
	// received byte
	output logic      [7:0] byte_o,
	output logic            valid_o
);

	localparam logic [6:0] BIT_LAST = 7'(`BIT_CYC - 1);
	localparam logic [6:0] BIT_HALF = 7'(`BIT_CYC / 2);

	logic       busy_q;
	logic [3:0] bit_q;
	logic [6:0] tick_q;
	logic [7:0] shift_q;

	// bit sampler, centred on each bit
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_q  <= 1'b0;
			bit_q   <= 4'h0;
			tick_q  <= 7'h00;
			shift_q <= 8'h00;
			valid_o <= 1'b0;
		end else begin
			valid_o <= 1'b0;
			if (!en_i) begin
				busy_q <= 1'b0;
			end else if (!busy_q) begin
				if (!line_i) begin
					busy_q <= 1'b1;
					bit_q  <= 4'h0;
					tick_q <= BIT_HALF;
				end
			end else if (tick_q != 7'h00) begin
				tick_q <= tick_q - 7'h01;
			end else begin
				tick_q <= BIT_LAST;
				if (bit_q == 4'h0) begin
					busy_q <= !line_i;     // start bit gone: glitch
					bit_q  <= 4'h1;
				end else if (bit_q != 4'h9) begin
					shift_q <= {shift_q[6:0], line_i};
					bit_q   <= bit_q + 4'h1;
				end else begin
					busy_q  <= 1'b0;
					valid_o <= line_i;     // framing error drops the byte
				end
			end
		end
	end

	assign byte_o = shift_q;

endmodule : frame_rx
`default_nettype wire

// *** verilog/link_pkg.sv ***
// types shared by the chain link block and its testbench
package link_pkg;

	// command engine states
	typedef enum logic [1:0] {S_HUNT, S_RECV, S_DELAY, S_SEND} cmd_state_t;

	// request to the device register file
	typedef struct packed {
		logic        we;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_t;

	// answer of the device register file
	typedef struct packed {
		logic [15:0] rdata;
		logic        crc_bad;
		logic        addr_bad;
		logic        diag_fault;
	} reg_rsp_t;

	// measurement results: 0 primary cell, 1 secondary cell, 2 block, 3 ext temp, 4 int temp, 5 diag resistance
	typedef logic [5:0][15:0] meas_set_t;

endpackage : link_pkg

// *** verilog/link_regs.svh ***
// register offsets, field positions, reset values and timing counts of the chain link block
`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH

// apb register byte offsets
`define CTRL_OFS       12'h000
`define MRCFG_OFS      12'h004
`define STAT_OFS       12'h008
`define ERRS_OFS       12'h00C

// control register fields
`define CTRL_ID_MSB    5
`define CTRL_ENUM_BIT  6
`define CTRL_SLEEP_BIT 8

// reset values
`define ID_RST         6'h00
`define MRCFG_RST      6'h01

// identifier codes
`define BCAST_ID       6'h3F
`define DFLT_ID        6'h00

// crc constants
`define CRC8_POLY      8'h1D
`define CRC8_INIT      8'hFF
`define CRC8_XOR       8'hFF
`define CRC3_POLY      3'h3

// timing: clock rate, bit time and reply delay
`define CLK_MHZ        200
`define BIT_NS         500
`define BIT_CYC        ((`BIT_NS * `CLK_MHZ) / 1000)
`define REPLY_TYP_NS   1700
`define REPLY_MAX_NS   3000
`define REPLY_CYC      ((`REPLY_TYP_NS * `CLK_MHZ) / 1000)
`define REPLY_MAX_CYC  ((`REPLY_MAX_NS * `CLK_MHZ) / 1000)

`endif
